// File: verilog/pfm_pkg.sv
// Constants, register map and helpers shared by the protection supervisor.
// What this block does
// (RULE1) Threshold configuration register accepts writes only while PWM run control is inactive.
// (RULE2) A threshold configuration write during PWM operation is dropped, keeping old values.
// (RULE3) Bit 5 picks upper power-good limit: set 105 percent, clear 110 percent.
// (RULE4) Bit 4 picks lower power-good limit: set 95 percent, clear 90 percent.
// (RULE5) Bits 3:2 pick overvoltage level 110, 120 or 130 percent; reset 130.
// (RULE6) Bits 1:0 pick undervoltage level 75, 80, 85 or 90 percent; reset 75.
// (RULE7) Every voltage threshold is a percentage of the present output setpoint.
// (RULE8) Warnings only report status; they never turn the output off.
// (RULE9) Thermal warning sets above 120 degrees and clears below 117 degrees.
// (RULE10) Armed and outside window: power-good pin pulled low, status bit zero.
// (RULE11) Power-good supervision arms only after turn-on reaches steady state.
// (RULE12) After steady state the pin stays low for a programmed 0 to 150 ms.
// (RULE13) Power-good stays armed during margining, limits scaling with the setpoint.
// (RULE14) Back inside window: pin released, status bit good, warning withdrawn.
// (RULE15) An external low on the power-good pin counts as a power-good warning.
// (RULE16) Option picks power-good low on turn-off command or at ramp-down start.
// (RULE17) Overcurrent or undervoltage faults turn the output off.
// (RULE18) Overcurrent check armed only while output exceeds the pre-bias voltage.
// (RULE19) Current at limit: overcurrent status zero, both power switches off at once.
// (RULE20) Overcurrent threshold gets temperature compensation above room unless disabled.
// (RULE21) Software keeps the load-regulation bits intact when writing the current limit.
// (RULE22) Undervoltage check armed only during steady-state operation.
// (RULE23) Undervoltage without overcurrent: undervoltage status zero, regular ramped turn-off.
// (RULE24) Non-latching protection retries turn-on every 130 ms after a shutdown.
package pfm_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ADDR_PROT_CFG = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_CUR_LIM = 8'h21;
	localparam logic [7:0] ADDR_PG_DELAY = 8'h22;
	localparam logic [7:0] ADDR_OPTIONS = 8'h23;

	localparam logic [5:0] PROT_CFG_RST = 6'h08;
	localparam logic [7:0] CUR_LIM_RST = 8'h0f;
	localparam logic [7:0] PG_DELAY_RST = 8'h00;
	localparam logic [1:0] OPTIONS_RST = 2'h0;

	localparam int PGH_BIT = 5;
	localparam int PGL_BIT = 4;
	localparam int OVP_LSB = 2;
	localparam int UVP_LSB = 0;

	localparam int STS_OC_BIT = 0;
	localparam int STS_UV_BIT = 1;
	localparam int STS_PG_BIT = 2;
	localparam int STS_TW_BIT = 3;

	localparam int CL_LIM_LSB = 0;
	localparam int CL_REG_LSB = 4;
	localparam int CL_TC_DIS_BIT = 7;

	localparam int OPT_PG_IMM_BIT = 0;
	localparam int OPT_NONLATCH_BIT = 1;

	// ************************************************************
	// Percentages of the setpoint (105, 110, 90, 95, 120, 130, 75, 80, 85)
	// ************************************************************
	localparam logic [7:0] PCT_105 = 8'h69;
	localparam logic [7:0] PCT_110 = 8'h6e;
	localparam logic [7:0] PCT_90 = 8'h5a;
	localparam logic [7:0] PCT_95 = 8'h5f;
	localparam logic [7:0] PCT_120 = 8'h78;
	localparam logic [7:0] PCT_130 = 8'h82;
	localparam logic [7:0] PCT_75 = 8'h4b;
	localparam logic [7:0] PCT_80 = 8'h50;
	localparam logic [7:0] PCT_85 = 8'h55;
	localparam logic [19:0] PCT_DIV = 20'h00064;

	// ************************************************************
	// Temperatures in degrees (120, 117, room 25) and limit shift
	// ************************************************************
	localparam logic [7:0] TW_SET_C = 8'h78;
	localparam logic [7:0] TW_CLR_C = 8'h75;
	localparam logic [7:0] ROOM_C = 8'h19;
	localparam int TC_SHIFT = 2;
	localparam int OC_SCALE_SHIFT = 4;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
	localparam logic [7:0] RETRY_MS = 8'h82;
	localparam logic [7:0] PG_DELAY_MAX_MS = 8'h96;

	typedef enum logic [2:0] {
		ST_MON = 3'h1,
		ST_FAST_OFF = 3'h2,
		ST_REG_OFF = 3'h4
	} pfm_state_e;

	// Scales a setpoint by a percentage, rounding down.
	function automatic logic [12:0] pct_of(input logic [11:0] v, input logic [7:0] p);
		logic [19:0] prod;
		prod = 20'(v) * 20'(p);
		return 13'(prod / PCT_DIV);
	endfunction : pct_of

endpackage : pfm_pkg

// File: verilog/pfm_thr_if.sv
// Bundle between the supervisor and its threshold calculator.
`timescale 1ns/1ps
interface pfm_thr_if;
	logic [11:0] setpoint;
	logic [5:0] cfg;
	logic [12:0] pg_hi;
	logic [12:0] pg_lo;
	logic [12:0] ov_lvl;
	logic [12:0] uv_lvl;

	modport calc (input setpoint, input cfg, output pg_hi, output pg_lo, output ov_lvl,
		output uv_lvl);
	modport mon (output setpoint, output cfg, input pg_hi, input pg_lo, input ov_lvl,
		input uv_lvl);
endinterface : pfm_thr_if

// File: verilog/pfm_thresholds.sv
// Threshold calculator: scales the live setpoint by the selected percentages.
`timescale 1ns/1ps
module pfm_thresholds (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	pfm_thr_if.calc thr
);

	logic [1:0] ovp_sel;
	logic [1:0] uvp_sel;
	logic [7:0] pct_hi;
	logic [7:0] pct_lo;
	logic [7:0] pct_ov;
	logic [7:0] pct_uv;

	assign ovp_sel = thr.cfg[pfm_pkg::OVP_LSB +: 2];
	assign uvp_sel = thr.cfg[pfm_pkg::UVP_LSB +: 2];
	assign pct_hi = thr.cfg[pfm_pkg::PGH_BIT] ? pfm_pkg::PCT_105 : pfm_pkg::PCT_110; // [RULE3]
	assign pct_lo = thr.cfg[pfm_pkg::PGL_BIT] ? pfm_pkg::PCT_95 : pfm_pkg::PCT_90; // [RULE4]
	// Codes 10 and 11 both give the top level. [RULE5]
	assign pct_ov = (ovp_sel == 2'h0) ? pfm_pkg::PCT_110 :
		(ovp_sel == 2'h1) ? pfm_pkg::PCT_120 : pfm_pkg::PCT_130;
	assign pct_uv = (uvp_sel == 2'h0) ? pfm_pkg::PCT_75 :
		(uvp_sel == 2'h1) ? pfm_pkg::PCT_80 :
		(uvp_sel == 2'h2) ? pfm_pkg::PCT_85 : pfm_pkg::PCT_90; // [RULE6]

	// Recomputed every cycle so margining moves the limits too. [RULE7] [RULE13]
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			thr.pg_hi <= 13'h0000;
			thr.pg_lo <= 13'h0000;
			thr.ov_lvl <= 13'h0000;
			thr.uv_lvl <= 13'h0000;
		end
		else
		begin
			thr.pg_hi <= pfm_pkg::pct_of(thr.setpoint, pct_hi);
			thr.pg_lo <= pfm_pkg::pct_of(thr.setpoint, pct_lo);
			thr.ov_lvl <= pfm_pkg::pct_of(thr.setpoint, pct_ov);
			thr.uv_lvl <= pfm_pkg::pct_of(thr.setpoint, pct_uv);
		end
	end

endmodule : pfm_thresholds

// File: verilog/pfm_fault_monitor.sv
// Protection supervisor: warnings, power-good pin, faults and retry.
`timescale 1ns/1ps
module pfm_fault_monitor #(
	parameter int CYC_PER_MS = pfm_pkg::CYC_PER_MS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	input wire logic pwm_run_i,
	input wire logic [11:0] vout_setpoint_i,
	input wire logic [11:0] vout_meas_i,
	input wire logic [11:0] prebias_i,
	input wire logic [7:0] iout_meas_i,
	input wire logic [7:0] temp_c_i,
	input wire logic steady_state_i,
	input wire logic turn_off_cmd_i,
	input wire logic ramp_down_i,
	input wire logic pg_pin_i,
	output logic pg_pin_o,
	output logic pg_pin_oe_o,
	output logic fast_off_o,
	output logic regular_off_o,
	output logic retry_on_o,
	output logic thermal_warn_o,
	output logic pg_warn_o,
	output logic [12:0] ov_level_o,
	output logic [2:0] load_reg_o
);

	// ************************************************************
	// Registers
	// ************************************************************
	logic [5:0] prot_cfg;
	logic [7:0] cur_lim;
	logic [7:0] pg_delay_ms;
	logic [1:0] options;
	logic oc_seen;
	logic uv_seen;
	pfm_pkg::pfm_state_e state;
	pfm_pkg::pfm_state_e next_state;
	logic oc_hit;
	logic uv_hit;

	logic wr_prot;
	logic wr_status;
	logic wr_cur_lim;
	logic wr_pg_delay;
	logic wr_options;
	logic [7:0] pg_delay_clamped;
	logic [7:0] status_word;
	logic [7:0] rd_value;
	logic next_oc_seen;
	logic next_uv_seen;

	assign wr_prot = cfg_wr_i && (cfg_addr_i == pfm_pkg::ADDR_PROT_CFG) && !pwm_run_i; // [RULE1]
	assign wr_status = cfg_wr_i && (cfg_addr_i == pfm_pkg::ADDR_STATUS);
	assign wr_cur_lim = cfg_wr_i && (cfg_addr_i == pfm_pkg::ADDR_CUR_LIM);
	assign wr_pg_delay = cfg_wr_i && (cfg_addr_i == pfm_pkg::ADDR_PG_DELAY);
	assign wr_options = cfg_wr_i && (cfg_addr_i == pfm_pkg::ADDR_OPTIONS);
	assign pg_delay_clamped = (cfg_wdata_i > pfm_pkg::PG_DELAY_MAX_MS) ?
		pfm_pkg::PG_DELAY_MAX_MS : cfg_wdata_i; // [RULE12]

	// Status bits are active low; software writes 1 to restore a latched bit.
	assign status_word = {4'h0, ~thermal_warn_o, ~pg_warn_o, ~uv_seen, ~oc_seen};
	assign rd_value = (cfg_addr_i == pfm_pkg::ADDR_PROT_CFG) ? {2'h0, prot_cfg} :
		(cfg_addr_i == pfm_pkg::ADDR_STATUS) ? status_word :
		(cfg_addr_i == pfm_pkg::ADDR_CUR_LIM) ? cur_lim :
		(cfg_addr_i == pfm_pkg::ADDR_PG_DELAY) ? pg_delay_ms :
		(cfg_addr_i == pfm_pkg::ADDR_OPTIONS) ? {6'h00, options} : 8'h00;

	// A new fault in the clearing cycle keeps its bit set.
	assign next_oc_seen = oc_hit ||
		(oc_seen && !(wr_status && cfg_wdata_i[pfm_pkg::STS_OC_BIT])); // [RULE19]
	assign next_uv_seen = uv_hit ||
		(uv_seen && !(wr_status && cfg_wdata_i[pfm_pkg::STS_UV_BIT])); // [RULE23]

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prot_cfg <= pfm_pkg::PROT_CFG_RST;
			cur_lim <= pfm_pkg::CUR_LIM_RST;
			pg_delay_ms <= pfm_pkg::PG_DELAY_RST;
			options <= pfm_pkg::OPTIONS_RST;
			oc_seen <= 1'b0;
			uv_seen <= 1'b0;
			cfg_rdata_o <= 8'h00;
		end
		else
		begin
			if (wr_prot)
				prot_cfg <= cfg_wdata_i[5:0]; // [RULE2]
			if (wr_cur_lim)
				cur_lim <= cfg_wdata_i;
			if (wr_pg_delay)
				pg_delay_ms <= pg_delay_clamped;
			if (wr_options)
				options <= cfg_wdata_i[1:0];
			oc_seen <= next_oc_seen;
			uv_seen <= next_uv_seen;
			if (cfg_rd_i)
				cfg_rdata_o <= rd_value;
		end
	end

	// ************************************************************
	// Thresholds
	// ************************************************************
	pfm_thr_if thr ();

	assign thr.setpoint = vout_setpoint_i;
	assign thr.cfg = prot_cfg;

	pfm_thresholds u_thresholds (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.thr(thr.calc)
	);

	// ************************************************************
	// Pin synchroniser and millisecond tick
	// ************************************************************
	logic pg_s1;
	logic pg_s2;
	logic pg_s3;
	logic pg_level;
	logic [31:0] ms_cnt;
	logic ms_tick;
	logic ms_wrap;

	assign ms_wrap = (ms_cnt == 32'(CYC_PER_MS - 1));

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pg_s1 <= 1'b1;
			pg_s2 <= 1'b1;
			pg_s3 <= 1'b1;
			pg_level <= 1'b1;
			ms_cnt <= 32'h00000000;
			ms_tick <= 1'b0;
		end
		else
		begin
			pg_s1 <= pg_pin_i;
			pg_s2 <= pg_s1;
			pg_s3 <= pg_s2;
			if (pg_s2 == pg_s3)
				pg_level <= pg_s3;
			ms_cnt <= ms_wrap ? 32'h00000000 : ms_cnt + 32'h00000001;
			ms_tick <= ms_wrap;
		end
	end

	// ************************************************************
	// Thermal warning
	// ************************************************************
	logic next_tw;

	assign next_tw = (temp_c_i > pfm_pkg::TW_SET_C) ||
		(thermal_warn_o && !(temp_c_i < pfm_pkg::TW_CLR_C)); // [RULE8] [RULE9]

	// ************************************************************
	// Power good
	// ************************************************************
	logic [7:0] pg_dly_cnt;
	logic pg_dly_done;
	logic [3:0] oe_hist;
	logic in_window;
	logic off_force;
	logic ext_low;
	logic next_pg_ok;

	assign in_window = ({1'b0, vout_meas_i} >= thr.pg_lo) &&
		({1'b0, vout_meas_i} <= thr.pg_hi); // [RULE10] [RULE13]
	assign off_force = options[pfm_pkg::OPT_PG_IMM_BIT] ? turn_off_cmd_i : ramp_down_i; // [RULE16]
	// The pin's own release takes a few cycles to reach pg_level; ignore it then.
	assign ext_low = !pg_level && !pg_pin_oe_o && (oe_hist == 4'h0); // [RULE15]
	assign next_pg_ok = steady_state_i && pg_dly_done && in_window && !off_force &&
		(state == pfm_pkg::ST_MON); // [RULE11] [RULE14]

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pg_dly_cnt <= 8'h00;
			pg_dly_done <= 1'b0;
		end
		else if (!steady_state_i)
		begin
			pg_dly_cnt <= 8'h00;
			pg_dly_done <= 1'b0;
		end
		else if (!pg_dly_done)
		begin
			if (pg_dly_cnt >= pg_delay_ms)
				pg_dly_done <= 1'b1; // [RULE12]
			else if (ms_tick)
				pg_dly_cnt <= pg_dly_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pg_pin_o <= 1'b0;
			pg_pin_oe_o <= 1'b1;
			pg_warn_o <= 1'b1;
			oe_hist <= 4'hf;
			thermal_warn_o <= 1'b0;
		end
		else
		begin
			pg_pin_o <= 1'b0;
			pg_pin_oe_o <= !next_pg_ok; // [RULE10] [RULE14]
			pg_warn_o <= !next_pg_ok || ext_low; // [RULE15]
			oe_hist <= {oe_hist[2:0], pg_pin_oe_o};
			thermal_warn_o <= next_tw;
		end
	end

	// ************************************************************
	// Faults and retry
	// ************************************************************
	logic [7:0] retry_cnt;
	logic retry_fire;
	logic oc_armed;
	logic [7:0] temp_over;
	logic [5:0] tc_comp;
	logic [8:0] oc_thr;

	assign oc_armed = vout_meas_i > prebias_i; // [RULE18]
	assign temp_over = (temp_c_i > pfm_pkg::ROOM_C) ? temp_c_i - pfm_pkg::ROOM_C : 8'h00;
	assign tc_comp = cur_lim[pfm_pkg::CL_TC_DIS_BIT] ? 6'h00 :
		6'(temp_over >> pfm_pkg::TC_SHIFT); // [RULE20]
	assign oc_thr = 9'({cur_lim[pfm_pkg::CL_LIM_LSB +: 4], 4'h0}) + 9'(tc_comp);
	assign oc_hit = (state == pfm_pkg::ST_MON) && oc_armed &&
		({1'b0, iout_meas_i} >= oc_thr); // [RULE19]
	assign uv_hit = (state == pfm_pkg::ST_MON) && steady_state_i && !oc_hit &&
		({1'b0, vout_meas_i} < thr.uv_lvl); // [RULE22] [RULE23]
	assign retry_fire = (state != pfm_pkg::ST_MON) && options[pfm_pkg::OPT_NONLATCH_BIT] &&
		ms_tick && (retry_cnt == pfm_pkg::RETRY_MS - 8'h01); // [RULE24]

	always_comb
	begin
		next_state = state;
		case (state)
			pfm_pkg::ST_MON:
			begin
				if (oc_hit)
					next_state = pfm_pkg::ST_FAST_OFF; // [RULE17] [RULE19]
				else if (uv_hit)
					next_state = pfm_pkg::ST_REG_OFF; // [RULE17] [RULE23]
			end
			pfm_pkg::ST_FAST_OFF,
			pfm_pkg::ST_REG_OFF:
			begin
				if (retry_fire)
					next_state = pfm_pkg::ST_MON;
			end
			default:
				next_state = pfm_pkg::ST_MON;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= pfm_pkg::ST_MON;
			retry_cnt <= 8'h00;
			fast_off_o <= 1'b0;
			regular_off_o <= 1'b0;
			retry_on_o <= 1'b0;
			ov_level_o <= 13'h0000;
			load_reg_o <= 3'h0;
		end
		else
		begin
			state <= next_state;
			if (state == pfm_pkg::ST_MON || retry_fire)
				retry_cnt <= 8'h00;
			else if (ms_tick)
				retry_cnt <= retry_cnt + 8'h01;
			fast_off_o <= (next_state == pfm_pkg::ST_FAST_OFF);
			regular_off_o <= (next_state == pfm_pkg::ST_REG_OFF);
			retry_on_o <= retry_fire;
			ov_level_o <= thr.ov_lvl;
			load_reg_o <= cur_lim[pfm_pkg::CL_REG_LSB +: 3];
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	a_cfg_write_taken: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE1]
		(cfg_wr_i && cfg_addr_i == pfm_pkg::ADDR_PROT_CFG && !pwm_run_i)
		|=> (prot_cfg == $past(cfg_wdata_i[5:0])))
		else $error("threshold config write while stopped was not stored");

	a_cfg_write_locked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE2]
		(cfg_wr_i && cfg_addr_i == pfm_pkg::ADDR_PROT_CFG && pwm_run_i) |=> $stable(prot_cfg))
		else $error("threshold config changed while PWM active");

	a_oc_fast_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE19]
		oc_hit |=> (fast_off_o && !regular_off_o && status_word[pfm_pkg::STS_OC_BIT] == 1'b0))
		else $error("overcurrent did not force fast turn-off");

	a_uv_regular_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE23]
		uv_hit |=> (regular_off_o && !fast_off_o && status_word[pfm_pkg::STS_UV_BIT] == 1'b0))
		else $error("undervoltage did not force regular turn-off");

	a_warn_no_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE8]
		(state == pfm_pkg::ST_MON && !oc_hit && !uv_hit) |=> (!fast_off_o && !regular_off_o))
		else $error("output turned off without a fault");

	a_tw_hyst: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE9]
		(temp_c_i > pfm_pkg::TW_SET_C) ##1 (temp_c_i >= pfm_pkg::TW_CLR_C) [*2]
		|=> thermal_warn_o)
		else $error("thermal warning lost inside hysteresis band");

	a_pg_ramp_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE11]
		!steady_state_i |=> (pg_pin_oe_o && pg_warn_o))
		else $error("power-good released before steady state");

	a_pg_window: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE10]
		(steady_state_i && !in_window) |=> (pg_pin_oe_o && status_word[pfm_pkg::STS_PG_BIT] == 1'b0))
		else $error("power-good not pulled low outside window");

	a_retry_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE24]
		retry_on_o |-> ($past(retry_cnt) == pfm_pkg::RETRY_MS - 8'h01 && state == pfm_pkg::ST_MON))
		else $error("retry fired at the wrong time");

endmodule : pfm_fault_monitor

// File: testbench/pfm_pg_pull_model.sv
// Power-good wire model: weak pull-up, our open drain and an outside pull-down.
`timescale 1ns/1ps
module pfm_pg_pull_model (
	input wire logic drv_i,
	input wire logic oe_i,
	input wire logic ext_low_i,
	output logic pin_o
);
	// The line idles high and goes low if either party pulls it.
	assign pin_o = ~((oe_i & ~drv_i) | ext_low_i);
endmodule : pfm_pg_pull_model

// File: testbench/test_pol_fault_warning_monitor.sv
// Self-checking bench for the protection supervisor.
`timescale 1ns/1ps
module test_pol_fault_warning_monitor;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cfg_wr_i = 1'b0;
	logic cfg_rd_i = 1'b0;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [7:0] cfg_wdata_i = 8'h00;
	logic pwm_run_i = 1'b0;
	logic [11:0] vout_setpoint_i = 12'h3e8;
	logic [11:0] vout_meas_i = 12'h000;
	logic [11:0] prebias_i = 12'h000;
	logic [7:0] iout_meas_i = 8'h00;
	logic [7:0] temp_c_i = 8'h19;
	logic steady_state_i = 1'b0;
	logic turn_off_cmd_i = 1'b0;
	logic ramp_down_i = 1'b0;
	logic ext_low = 1'b0;
	logic pg_pin_i;
	logic [7:0] cfg_rdata_o;
	logic pg_pin_o, pg_pin_oe_o, fast_off_o, regular_off_o, retry_on_o;
	logic thermal_warn_o, pg_warn_o;
	logic [12:0] ov_level_o;
	logic [2:0] load_reg_o;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	localparam logic [7:0] TMP [5] = '{8'h78, 8'h79, 8'h76, 8'h75, 8'h74};
	localparam logic TWX [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
	localparam logic [7:0] WC [9] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h28, 8'h18,
		8'h18};
	localparam logic [11:0] WV [9] = '{12'h47e, 12'h41a, 12'h44c, 12'h352, 12'h398, 12'h383,
		12'h438, 12'h398, 12'h3c0};
	localparam logic WOE [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
	localparam logic [12:0] OVX [4] = '{13'h44c, 13'h4b0, 13'h514, 13'h514};
	localparam logic [11:0] UVL [4] = '{12'h2ee, 12'h320, 12'h352, 12'h384};

	pfm_fault_monitor #(.CYC_PER_MS(20)) pfm_fault_monitor_i (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .pwm_run_i(pwm_run_i),
		.vout_setpoint_i(vout_setpoint_i), .vout_meas_i(vout_meas_i), .prebias_i(prebias_i),
		.iout_meas_i(iout_meas_i), .temp_c_i(temp_c_i), .steady_state_i(steady_state_i),
		.turn_off_cmd_i(turn_off_cmd_i), .ramp_down_i(ramp_down_i), .pg_pin_i(pg_pin_i),
		.pg_pin_o(pg_pin_o), .pg_pin_oe_o(pg_pin_oe_o), .fast_off_o(fast_off_o),
		.regular_off_o(regular_off_o), .retry_on_o(retry_on_o),
		.thermal_warn_o(thermal_warn_o), .pg_warn_o(pg_warn_o), .ov_level_o(ov_level_o),
		.load_reg_o(load_reg_o));

	pfm_pg_pull_model pfm_pg_pull_model_i (.drv_i(pg_pin_o), .oe_i(pg_pin_oe_o),
		.ext_low_i(ext_low), .pin_o(pg_pin_i));

	// ************************************************************
	// Clock, timeout and shared tasks
	// ************************************************************
	always #5 clk_sys_i = ~clk_sys_i;

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask : tick

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cfg_addr_i = a;
		cfg_wdata_i = d;
		cfg_wr_i = 1'b1;
		tick(1);
		cfg_wr_i = 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		cfg_addr_i = a;
		cfg_rd_i = 1'b1;
		tick(1);
		cfg_rd_i = 1'b0;
		tick(1);
		chk(16'(cfg_rdata_o), 16'(e));
	endtask : rd

	task automatic reset_dut();
		rst_n_i = 1'b0;
		tick(2);
		rst_n_i = 1'b1;
		tick(1);
	endtask : reset_dut

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial
	begin
		repeat (20) @(posedge clk_sys_i);
		#1;
		rst_n_i = 1'b1;
		tick(1);
		rd(8'h01, 8'h08);
		rd(8'h21, 8'h0f);
		rd(8'h05, 8'h00);
		rd(8'h20, 8'h0b);
		pwm_run_i = 1'b1;
		wr(8'h01, 8'h3f);
		rd(8'h01, 8'h08);
		pwm_run_i = 1'b0;
		wr(8'h01, 8'hff);
		rd(8'h01, 8'h3f);
		vout_meas_i = 12'h3e8;
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h01, 8'(c << 2));
			tick(3);
			chk(16'(ov_level_o), 16'(OVX[c]));
		end
		vout_setpoint_i = 12'h7d0;
		tick(3);
		chk(16'(ov_level_o), 16'h0a28);
		vout_setpoint_i = 12'h3e8;
		wr(8'h01, 8'h08);
		chk(16'(pg_pin_oe_o), 16'h1);
		for (int t = 0; t < 5; t++)
		begin
			temp_c_i = TMP[t];
			tick(3);
			chk(16'(thermal_warn_o), 16'(TWX[t]));
			chk(16'({fast_off_o, regular_off_o}), 16'h0);
		end
		temp_c_i = 8'h19;
		steady_state_i = 1'b1;
		tick(6);
		chk(16'(pg_pin_oe_o), 16'h0);
		for (int w = 0; w < 9; w++)
		begin
			wr(8'h01, WC[w]);
			vout_meas_i = WV[w];
			tick(4);
			chk(16'(pg_pin_oe_o), 16'(WOE[w]));
			chk(16'(pg_warn_o), 16'(WOE[w]));
		end
		wr(8'h01, 8'h08);
		vout_setpoint_i = 12'h4b0;
		vout_meas_i = 12'h4b0;
		tick(4);
		chk(16'(pg_pin_oe_o), 16'h0);
		vout_setpoint_i = 12'h3e8;
		vout_meas_i = 12'h47e;
		tick(4);
		rd(8'h20, 8'h0b);
		chk(16'({pg_pin_o, pg_pin_i}), 16'h0);
		vout_meas_i = 12'h3e8;
		tick(4);
		rd(8'h20, 8'h0f);
		ext_low = 1'b1;
		tick(10);
		chk(16'(pg_warn_o), 16'h1);
		ext_low = 1'b0;
		tick(10);
		chk(16'(pg_warn_o), 16'h0);
		steady_state_i = 1'b0;
		reset_dut();
		wr(8'h22, 8'hc8);
		rd(8'h22, 8'h96);
		wr(8'h22, 8'h02);
		steady_state_i = 1'b1;
		tick(15);
		chk(16'(pg_pin_oe_o), 16'h1);
		tick(45);
		chk(16'(pg_pin_oe_o), 16'h0);
		wr(8'h23, 8'h01);
		turn_off_cmd_i = 1'b1;
		tick(4);
		chk(16'(pg_pin_oe_o), 16'h1);
		turn_off_cmd_i = 1'b0;
		reset_dut();
		tick(6);
		turn_off_cmd_i = 1'b1;
		tick(4);
		chk(16'(pg_pin_oe_o), 16'h0);
		ramp_down_i = 1'b1;
		tick(4);
		chk(16'(pg_pin_oe_o), 16'h1);
		turn_off_cmd_i = 1'b0;
		ramp_down_i = 1'b0;
		reset_dut();
		iout_meas_i = 8'hef;
		tick(4);
		chk(16'(fast_off_o), 16'h0);
		iout_meas_i = 8'hf0;
		tick(2);
		chk(16'({fast_off_o, regular_off_o}), 16'h2);
		iout_meas_i = 8'h00;
		tick(10);
		chk(16'(fast_off_o), 16'h1);
		rd(8'h20, 8'h0a);
		prebias_i = 12'h1f4;
		vout_meas_i = 12'h190;
		steady_state_i = 1'b0;
		reset_dut();
		iout_meas_i = 8'hff;
		tick(4);
		chk(16'(fast_off_o), 16'h0);
		prebias_i = 12'h000;
		vout_meas_i = 12'h3e8;
		temp_c_i = 8'h41;
		iout_meas_i = 8'hf5;
		wr(8'h21, 8'h2f);
		tick(3);
		chk(16'(fast_off_o), 16'h0);
		chk(16'(load_reg_o), 16'h2);
		rd(8'h21, 8'h2f);
		wr(8'h21, cfg_rdata_o | 8'h80);
		tick(3);
		chk(16'(fast_off_o), 16'h1);
		chk(16'(load_reg_o), 16'h2);
		temp_c_i = 8'h19;
		iout_meas_i = 8'h00;
		for (int c = 0; c < 4; c++)
		begin
			steady_state_i = 1'b0;
			reset_dut();
			wr(8'h01, 8'(c));
			vout_meas_i = UVL[c] - 12'h001;
			tick(4);
			chk(16'(regular_off_o), 16'h0);
			vout_meas_i = UVL[c];
			steady_state_i = 1'b1;
			tick(4);
			chk(16'(regular_off_o), 16'h0);
			vout_meas_i = UVL[c] - 12'h001;
			tick(3);
			chk(16'({fast_off_o, regular_off_o}), 16'h1);
		end
		rd(8'h20, 8'h09);
		reset_dut();
		vout_meas_i = 12'h3e8;
		tick(4);
		vout_meas_i = 12'h2bc;
		iout_meas_i = 8'hf0;
		tick(3);
		chk(16'({fast_off_o, regular_off_o}), 16'h2);
		iout_meas_i = 8'h00;
		vout_meas_i = 12'h3e8;
		reset_dut();
		wr(8'h23, 8'h02);
		iout_meas_i = 8'hf0;
		tick(2);
		iout_meas_i = 8'h00;
		n = 0;
		while (retry_on_o !== 1'b1 && n < 3000)
		begin
			tick(1);
			n++;
		end
		chk(16'(n >= 2590 && n <= 2610), 16'h1);
		chk(16'(fast_off_o), 16'h0);
		report_and_stop();
	end
endmodule : test_pol_fault_warning_monitor
